// ### bench/fan_model.sv
// Cooling fan stand-in that times each PWM period and its high part.
`timescale 1ns/1ps
module fan_model (
    input wire logic sys_clk,
    input wire logic pwm,
    output logic [15:0] hi_cycles,
    output logic [15:0] per_cycles
);
    logic last = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] hcnt = 16'h0000;
    // A period runs from one rising edge of the drive to the next.
    always @(posedge sys_clk) begin
        last <= pwm;
        if (pwm && !last) begin
            per_cycles <= cnt;
            hi_cycles <= hcnt;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, pwm};
        end
    end
endmodule : fan_model

// ### bench/tb_top.sv
// Self-checking bench of the automatic fan PWM control loop.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] local_temp = 8'h00;
    logic [7:0] remote_temp = 8'h00;
    logic temp_update = 1'b0;
    logic pwm_out;
    logic spin_active;
    logic [2:0] adc_rate_sel;
    logic [1:0] speed_range_sel;
    logic [15:0] hi_cycles;
    logic [15:0] per_cycles;
    logic rd_ph = 1'b0;
    logic [7:0] exp_q [$];
    logic [7:0] ridx [4] = '{8'h20, 8'h22, 8'h24, 8'h25};
    logic [7:0] rrst [4] = '{8'h5D, 8'h05, 8'h43, 8'h43};
    logic [7:0] h;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 32'hC792;
    int t;

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Short slot and spin tick keep a PWM period near 720 cycles.
    auto_fan_pwm_control_loop #(.PWM_CLK_KHZ(24), .SPIN_TICK_CYC(10))
        i_auto_fan_pwm_control_loop (.sys_clk(sys_clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .local_temp(local_temp), .remote_temp(remote_temp),
        .temp_update(temp_update), .pwm_out(pwm_out),
        .spin_active(spin_active), .adc_rate_sel(adc_rate_sel),
        .speed_range_sel(speed_range_sel));

    fan_model i_fan_model (.sys_clk(sys_clk), .pwm(pwm_out),
        .hi_cycles(hi_cycles), .per_cycles(per_cycles));

    task check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // One single word transfer; a read notes its expected byte.
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd_ph <= !wr;
        if (!wr) exp_q.push_back(d);
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : bus

    task pulse(input logic [7:0] l, input logic [7:0] r);
        local_temp <= l;
        remote_temp <= r;
        temp_update <= 1'b1;
        @(posedge sys_clk);
        temp_update <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse

    // Waiting four periods lets a new duty reach the pin and be timed.
    task upd(input logic [7:0] l, input logic [7:0] r);
        pulse(l, r);
        repeat (3000) @(posedge sys_clk);
    endtask : upd

    always @(posedge sys_clk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            check("hrdata", hrdata, {24'h0, exp_q.pop_front()});
            check("hresp", hresp, 32'h0);
        end
    end

    initial begin
        repeat (95000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, 8'h00, 8'h80);
        bus(1'b0, 8'h20, 8'h5D);
        bus(1'b0, 8'h22, 8'h05);
        bus(1'b0, 8'h23, 8'h10);
        bus(1'b0, 8'h24, 8'h43);
        bus(1'b0, 8'h25, 8'h43);
        bus(1'b0, 8'h30, 8'h00);
        check("range", speed_range_sel, 2'h1);
        check("rate", adc_rate_sel, 3'h4);
        for (int i = 0; i < 4; i++) begin
            h = 8'($random(seed));
            bus(1'b1, ridx[i], h);
            bus(1'b0, ridx[i], h);
            bus(1'b1, ridx[i], rrst[i]);
        end
        $display("registers done");
        pulse(8'h00, 8'h28);
        t = 0;
        while (spin_active !== 1'b1 && t < 3000) begin
            @(posedge sys_clk);
            t++;
        end
        t = 0;
        while (spin_active === 1'b1 && t < 5000) begin
            @(posedge sys_clk);
            t++;
        end
        check("spin time", t, 32'h000000C8);
        repeat (3000) @(posedge sys_clk);
        bus(1'b0, 8'h26, 8'h70);
        $display("spin-up done");
        bus(1'b1, 8'h23, 8'h90);
        t = 32 + ($random(seed) & 15);
        upd(8'hC8, t[7:0]);
        bus(1'b0, 8'h26, 8'(80 + (t - 32) * 4));
        check("high", 32'(hi_cycles) * 240, 32'(per_cycles) * (80 + (t - 32) * 4));
        bus(1'b1, 8'h25, 8'h28);
        upd(8'h00, 8'h16);
        bus(1'b0, 8'h26, 8'h90);
        upd(8'h00, 8'h13);
        bus(1'b0, 8'h26, 8'h00);
        bus(1'b1, 8'h00, 8'hE0);
        bus(1'b1, 8'h24, 8'h44);
        upd(8'h3C, 8'h16);
        bus(1'b0, 8'h26, 8'h90);
        upd(8'h64, 8'h16);
        bus(1'b0, 8'h26, 8'hD8);
        upd(8'hC8, 8'h16);
        bus(1'b0, 8'h26, 8'hF0);
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h22, 8'h0A);
        repeat (3000) @(posedge sys_clk);
        bus(1'b0, 8'h26, 8'hA0);
        $display("automatic modes done");
        bus(1'b1, 8'h00, 8'h80);
        bus(1'b1, 8'h22, 8'h05);
        bus(1'b1, 8'h25, 8'h43);
        bus(1'b1, 8'h23, 8'hF1);
        repeat (3000) @(posedge sys_clk);
        repeat (40) pulse(8'h00, 8'h20);
        repeat (3000) @(posedge sys_clk);
        bus(1'b0, 8'h26, 8'h50);
        h = 8'h50;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'h23, 8'h91 | 8'(k << 5));
            repeat (3000) @(posedge sys_clk);
            upd(8'h00, 8'h34);
            h = h + 8'(1 << k);
            bus(1'b0, 8'h26, h);
        end
        upd(8'h00, 8'h24);
        bus(1'b0, 8'h26, 8'h60);
        upd(8'h00, 8'h14);
        bus(1'b0, 8'h26, 8'h58);
        bus(1'b1, 8'h20, 8'hDD);
        repeat (3000) @(posedge sys_clk);
        check("range", speed_range_sel, 2'h3);
        $display("filtered mode done");
        wrap_up();
    end
endmodule : tb_top

// ### rtl/auto_fan_pwm_control_loop.sv
// Automatic fan PWM control loop with AHB-Lite register access.
// ****************************************************************
// Overview of operation
// [RULE1] Top config bit picks automatic control
// [RULE2] Select remote alone or fastest channel
// [RULE3] Spin-up time code, default two seconds
// [RULE4] PWM frequency code, default 31.25 Hz
// [RULE5] Speed range divisor held in top bits
// [RULE6] Minimum duty code applies at turn-on
// [RULE7] Local turn-on temperature in 4 degree steps
// [RULE8] Span code selects 5 to 80 degrees
// [RULE9] Remote turn-on temperature, same encoding
// [RULE10] Filter bit zero enables ramped duty
// [RULE11] Period split into 240 slots
// [RULE12] Ramp step of 1, 2, 4, 8 slots
// [RULE13] Step held duty toward new target
// [RULE14] Unfiltered duty follows target at once
// [RULE15] Linear rise reaching full speed
// [RULE16] One ramp step per temperature update
// [RULE17] Sample rate code, default 1.4 kHz
// [RULE18] Clamp at full; steps never overshoot
// [RULE19] Settings apply at period boundary
// ****************************************************************
`timescale 1ns/1ps
`include "fan_cfg.svh"
module auto_fan_pwm_control_loop #(
    parameter int unsigned PWM_CLK_KHZ = `CLK_KHZ,
    parameter int unsigned SPIN_TICK_CYC = `CLK_KHZ * `SPIN_TICK_MS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] local_temp,
    input wire logic [7:0] remote_temp,
    input wire logic temp_update,
    output logic pwm_out,
    output logic spin_active,
    output logic [2:0] adc_rate_sel,
    output logic [1:0] speed_range_sel
);
    // ****************************************************************
    // Timing tables
    // ****************************************************************
    function automatic logic [23:0] slot_cycles(input logic [2:0] code);
        longint unsigned f;
        unique case (code) // RULE4
            3'h0: f = `PWM_MHZ_0;
            3'h1: f = `PWM_MHZ_1;
            3'h2: f = `PWM_MHZ_2;
            3'h3: f = `PWM_MHZ_3;
            3'h4: f = `PWM_MHZ_4;
            3'h5: f = `PWM_MHZ_5;
            3'h6: f = `PWM_MHZ_6;
            3'h7: f = `PWM_MHZ_7;
        endcase
        return 24'(longint'(PWM_CLK_KHZ) * 1000000 /
            (f * `SLOTS_PER_PERIOD));
    endfunction : slot_cycles

    function automatic logic [6:0] spin_ticks(input logic [2:0] code);
        int unsigned ms;
        unique case (code) // RULE3
            3'h0: ms = `SPIN_MS_0;
            3'h1: ms = `SPIN_MS_1;
            3'h2: ms = `SPIN_MS_2;
            3'h3: ms = `SPIN_MS_3;
            3'h4: ms = `SPIN_MS_4;
            3'h5: ms = `SPIN_MS_5;
            3'h6: ms = `SPIN_MS_6;
            3'h7: ms = `SPIN_MS_7;
        endcase
        return 7'(ms / `SPIN_TICK_MS);
    endfunction : spin_ticks

    function automatic logic [7:0] reg_read(input logic [7:0] idx,
        input fan_pkg::reg_set_t r, input logic [7:0] duty);
        case (idx)
            `IDX_CFG_ONE: reg_read = r.cfg_one;
            `IDX_FAN_CHAR: reg_read = r.fan_char;
            `IDX_FAN_SPEED: reg_read = r.fan_speed;
            `IDX_RAMP_FILTER: reg_read = r.ramp_filter;
            `IDX_LOCAL_THR: reg_read = r.local_thr;
            `IDX_REMOTE_THR: reg_read = r.remote_thr;
            `IDX_DUTY_STATUS: reg_read = duty;
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    localparam fan_pkg::reg_set_t RST_REGS = '{
        cfg_one: `RST_CFG_ONE,
        fan_char: `RST_FAN_CHAR,
        fan_speed: `RST_FAN_SPEED,
        ramp_filter: `RST_RAMP_FILTER,
        local_thr: `RST_LOCAL_THR,
        remote_thr: `RST_REMOTE_THR
    };
    localparam fan_pkg::top_state_t RST_STATE = '{
        regs: RST_REGS,
        active: RST_REGS,
        phase: fan_pkg::BUS_IDLE,
        ready: 1'b1,
        was_off: 1'b1,
        rate_sel: RST_REGS.ramp_filter[`RATE_HI:`RATE_LO],
        range_sel: RST_REGS.fan_char[`RANGE_HI:`RANGE_LO],
        default: '0
    };

    fan_pkg::top_state_t s;
    fan_pkg::top_state_t next_s;
    pwm_if link ();
    logic [7:0] local_duty;
    logic [7:0] remote_duty;
    logic [7:0] fastest;
    logic [7:0] target;
    logic [7:0] ramp_step;
    logic auto_mode;
    logic filt_en;
    logic spin_dis;
    logic [1:0] chan_sel;
    logic [7:0] idx;
    logic accept;

    // ****************************************************************
    // Channel loops and waveform
    // ****************************************************************
    channel_loop u_local (
        .temp(s.local_temp),
        .thr(s.active.local_thr),
        .minimum_duty_code(s.active.fan_speed[`MIN_HI:`MIN_LO]),
        .duty(local_duty)
    );

    channel_loop u_remote (
        .temp(s.remote_temp),
        .thr(s.active.remote_thr),
        .minimum_duty_code(s.active.fan_speed[`MIN_HI:`MIN_LO]),
        .duty(remote_duty)
    );

    pwm_wave u_wave (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .link(link.gen)
    );

    assign link.slot_cycles =
        slot_cycles(s.active.fan_char[`FREQ_HI:`FREQ_LO]); // RULE4
    assign link.duty = s.cmd;

    // ****************************************************************
    // Duty selection
    // ****************************************************************
    assign auto_mode = s.active.cfg_one[`AUTO_BIT]; // RULE1
    assign chan_sel = s.active.cfg_one[`SEL_HI:`SEL_LO];
    assign filt_en = s.active.ramp_filter[`FILT_EN_BIT]; // RULE10
    assign spin_dis = s.active.ramp_filter[`SPIN_DIS_BIT];
    assign ramp_step =
        8'h01 << s.active.ramp_filter[`RAMP_HI:`RAMP_LO]; // RULE12
    assign fastest = (local_duty > remote_duty) ? local_duty : remote_duty;
    // Codes 01 and 10 have no defined loop and fall back to remote alone.
    assign target = !auto_mode ?
        {s.active.fan_speed[`MIN_HI:`MIN_LO], 4'h0} :
        (chan_sel == `SEL_FASTEST) ? fastest : remote_duty; // RULE2
    assign idx = haddr[9:2];
    assign accept = hsel && hready && htrans[1];

    always_comb begin
        next_s = s;
        next_s.upd = temp_update;
        if (temp_update) begin
            next_s.local_temp = local_temp;
            next_s.remote_temp = remote_temp;
        end
        if (!(auto_mode && filt_en)) begin
            next_s.held = target; // RULE14
        end else if (s.upd) begin // RULE16
            if (target > s.held) begin // RULE13
                next_s.held = (8'(target - s.held) > ramp_step) ?
                    8'(s.held + ramp_step) : target; // RULE18
            end else if (target < s.held) begin
                next_s.held = (8'(s.held - target) > ramp_step) ?
                    8'(s.held - ramp_step) : target; // RULE18
            end
        end
        if (s.spin) begin
            if ({1'b0, s.tick_cnt} + 33'h000000001 >=
                {1'b0, 32'(SPIN_TICK_CYC)}) begin
                next_s.tick_cnt = 32'h00000000;
                if (s.spin_left <= 7'h01) begin
                    next_s.spin = 1'b0;
                end else begin
                    next_s.spin_left = s.spin_left - 7'h01;
                end
            end else begin
                next_s.tick_cnt = s.tick_cnt + 32'h00000001;
            end
        end
        if (link.period_end) begin
            next_s.active = s.regs; // RULE19
            next_s.was_off = (s.held == 8'h00);
            // A stopped fan turning on gets cmd at full for the spin time; the pin takes it at the next boundary.
            if (s.was_off && s.held != 8'h00 && !spin_dis) begin
                next_s.spin = 1'b1;
                next_s.spin_left =
                    spin_ticks(s.active.fan_char[`SPIN_HI:`SPIN_LO]); // RULE3
                next_s.tick_cnt = 32'h00000000;
            end
        end
        next_s.cmd = next_s.spin ? `SLOTS_PER_PERIOD : next_s.held;
        next_s.rate_sel = s.active.ramp_filter[`RATE_HI:`RATE_LO]; // RULE17
        next_s.range_sel = s.active.fan_char[`RANGE_HI:`RANGE_LO]; // RULE5
        unique case (s.phase)
            fan_pkg::BUS_WRITE: begin
                case (s.wr_idx)
                    `IDX_CFG_ONE: next_s.regs.cfg_one = hwdata[7:0];
                    `IDX_FAN_CHAR: next_s.regs.fan_char = hwdata[7:0];
                    `IDX_FAN_SPEED: next_s.regs.fan_speed = hwdata[7:0];
                    `IDX_RAMP_FILTER: next_s.regs.ramp_filter = hwdata[7:0];
                    `IDX_LOCAL_THR: next_s.regs.local_thr = hwdata[7:0];
                    `IDX_REMOTE_THR: next_s.regs.remote_thr = hwdata[7:0];
                    default: ;
                endcase
            end
            fan_pkg::BUS_IDLE, fan_pkg::BUS_READ: ;
        endcase
        next_s.phase = fan_pkg::BUS_IDLE;
        next_s.rdata = 32'h00000000;
        if (accept) begin
            next_s.wr_idx = idx;
            next_s.phase = hwrite ? fan_pkg::BUS_WRITE : fan_pkg::BUS_READ;
            // Reading from next_s forwards a write still in its data phase.
            if (!hwrite) begin
                next_s.rdata = {24'h000000, reg_read(idx, next_s.regs, s.cmd)};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.ready;
    assign hresp = 1'b0 & s.ready;
    assign hrdata = s.rdata;
    assign pwm_out = link.pwm;
    assign spin_active = s.spin;
    assign adc_rate_sel = s.rate_sel;
    assign speed_range_sel = s.range_sel;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_sw_mode;
        !auto_mode |=> s.held == {$past(s.active.fan_speed[3:0]), 4'h0};
    endproperty
    a_sw_mode: assert property (p_sw_mode) // RULE1
        else $error("software mode duty differs from speed nibble");

    property p_fastest;
        auto_mode && !filt_en && chan_sel == `SEL_FASTEST |=>
            s.held >= $past(local_duty) && s.held >= $past(remote_duty);
    endproperty
    a_fastest: assert property (p_fastest) // RULE2
        else $error("fastest channel did not drive the fan");

    property p_remote;
        auto_mode && !filt_en && chan_sel == `SEL_REMOTE |=>
            s.held == $past(remote_duty);
    endproperty
    a_remote: assert property (p_remote) // RULE14
        else $error("remote duty not applied at once");

    property p_step;
        auto_mode && filt_en && s.upd && target > 8'(s.held + ramp_step)
            |=> s.held == 8'($past(s.held) + $past(ramp_step));
    endproperty
    a_step: assert property (p_step) // RULE13
        else $error("filtered step size wrong");

    property p_no_overshoot;
        auto_mode && filt_en && s.upd && target >= s.held |=>
            s.held <= $past(target) && s.held >= $past(s.held);
    endproperty
    a_no_overshoot: assert property (p_no_overshoot) // RULE18
        else $error("filtered duty overshot its target");

    property p_hold;
        auto_mode && filt_en && !s.upd |=> s.held == $past(s.held);
    endproperty
    a_hold: assert property (p_hold) // RULE16
        else $error("filtered duty moved without an update");

    property p_cfg_boundary;
        !link.period_end |=> s.active == $past(s.active);
    endproperty
    a_cfg_boundary: assert property (p_cfg_boundary) // RULE19
        else $error("settings changed inside a period");

    sequence s_spin_start;
        link.period_end && s.was_off && s.held != 8'h00 && !spin_dis;
    endsequence
    property p_spin;
        s_spin_start |=> s.spin && s.spin_left ==
            spin_ticks($past(s.active.fan_char[2:0])) &&
            s.cmd == `SLOTS_PER_PERIOD;
    endproperty
    a_spin: assert property (p_spin) // RULE3
        else $error("spin-up not started with its time");

    property p_clamp;
        local_duty <= `SLOTS_PER_PERIOD && remote_duty <= `SLOTS_PER_PERIOD;
    endproperty
    a_clamp: assert property (p_clamp) // RULE18
        else $error("channel duty above full speed");

    property p_min_at_fan_turn_on_temperature;
        s.local_temp == {s.active.local_thr[7:3], 2'b00} |->
            local_duty == {s.active.fan_speed[3:0], 4'h0};
    endproperty
    a_min_at_fan_turn_on_temperature: assert property (p_min_at_fan_turn_on_temperature) // RULE6
        else $error("duty at turn-on temperature is not the minimum");
endmodule : auto_fan_pwm_control_loop

// ### rtl/channel_loop.sv
// Duty computation of one temperature channel, in time slots.
`timescale 1ns/1ps
`include "fan_cfg.svh"
module channel_loop (
    input wire logic [7:0] temp,
    input wire logic [7:0] thr,
    input wire logic [3:0] minimum_duty_code,
    output logic [7:0] duty
);
    logic [7:0] fan_turn_on_temperature;
    logic [2:0] control_span;

    // Turn-on point in 4 degree steps.
    assign fan_turn_on_temperature =
        {1'b0, thr[`FAN_TURN_ON_TEMPERATURE_HI:`FAN_TURN_ON_TEMPERATURE_LO], 2'b00}; // RULE7 RULE9
    // Codes above 80 degrees behave as 80 degrees.
    assign control_span = (thr[`SPAN_HI:`SPAN_LO] > `SPAN_CODE_MAX) ?
        `SPAN_CODE_MAX : thr[`SPAN_HI:`SPAN_LO]; // RULE8

    // One code is 16 slots; a span of 5 degrees covers 10 codes, so the
    // slope is 32 slots per degree halved for each span doubling.
    always_comb begin
        logic [7:0] diff;
        logic [12:0] rise;
        logic [13:0] sum;
        diff = 8'(temp - fan_turn_on_temperature);
        rise = 13'({5'h00, diff} << `SPAN_SLOT_SHIFT) >> control_span; // RULE15
        sum = {2'b00, minimum_duty_code, 8'h00} >> 4;
        sum = sum + {1'b0, rise}; // RULE6
        if (temp < fan_turn_on_temperature) begin
            duty = 8'h00;
        end else if (sum > {6'h00, `SLOTS_PER_PERIOD}) begin
            duty = `SLOTS_PER_PERIOD; // RULE18
        end else begin
            duty = sum[7:0];
        end
    end
endmodule : channel_loop

// ### rtl/fan_cfg.svh
// Offsets, field positions, reset values and timing figures of the fan loop.
`ifndef FAN_CFG_SVH
`define FAN_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CFG_ONE 8'h00
`define IDX_FAN_CHAR 8'h20
`define IDX_FAN_SPEED 8'h22
`define IDX_RAMP_FILTER 8'h23
`define IDX_LOCAL_THR 8'h24
`define IDX_REMOTE_THR 8'h25
`define IDX_DUTY_STATUS 8'h26

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CFG_ONE 8'h80
`define RST_FAN_CHAR 8'h5D
`define RST_FAN_SPEED 8'h05
`define RST_RAMP_FILTER 8'h10
`define RST_LOCAL_THR 8'h43
`define RST_REMOTE_THR 8'h43

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define AUTO_BIT 7
`define SEL_HI 6
`define SEL_LO 5
`define SEL_REMOTE 2'h0
`define SEL_FASTEST 2'h3
`define SPIN_HI 2
`define SPIN_LO 0
`define FREQ_HI 5
`define FREQ_LO 3
`define RANGE_HI 7
`define RANGE_LO 6
`define MIN_HI 3
`define MIN_LO 0
`define FAN_TURN_ON_TEMPERATURE_HI 7
`define FAN_TURN_ON_TEMPERATURE_LO 3
`define SPAN_HI 2
`define SPAN_LO 0
`define SPAN_CODE_MAX 3'h4
`define SPIN_DIS_BIT 7
`define RAMP_HI 6
`define RAMP_LO 5
`define RATE_HI 4
`define RATE_LO 2
`define FILT_EN_BIT 0

// ****************************************************************
// Duty scale and timing
// ****************************************************************
`define SLOTS_PER_PERIOD 8'hF0
`define SLOT_LAST 8'hEF
`define SPAN_SLOT_SHIFT 5
`define CLK_KHZ 250000
`define SPIN_TICK_MS 100
`define SPIN_MS_0 200
`define SPIN_MS_1 400
`define SPIN_MS_2 600
`define SPIN_MS_3 800
`define SPIN_MS_4 1000
`define SPIN_MS_5 2000
`define SPIN_MS_6 4000
`define SPIN_MS_7 8000
// PWM frequencies in milli-hertz.
`define PWM_MHZ_0 11700
`define PWM_MHZ_1 15600
`define PWM_MHZ_2 23400
`define PWM_MHZ_3 31250
`define PWM_MHZ_4 37500
`define PWM_MHZ_5 46900
`define PWM_MHZ_6 62500
`define PWM_MHZ_7 93500

`endif

// ### rtl/fan_pkg.sv
// Types shared by the fan control loop modules.
package fan_pkg;

    typedef struct packed {
        logic [7:0] cfg_one;
        logic [7:0] fan_char;
        logic [7:0] fan_speed;
        logic [7:0] ramp_filter;
        logic [7:0] local_thr;
        logic [7:0] remote_thr;
    } reg_set_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_phase_t;

    typedef struct packed {
        logic [23:0] cyc_cnt;
        logic [7:0] slot;
        logic [7:0] duty;
        logic pwm;
        logic period_end;
    } wave_state_t;

    typedef struct packed {
        reg_set_t regs;
        reg_set_t active;
        bus_phase_t phase;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
        logic upd;
        logic [7:0] local_temp;
        logic [7:0] remote_temp;
        logic [7:0] held;
        logic [7:0] cmd;
        logic was_off;
        logic spin;
        logic [6:0] spin_left;
        logic [31:0] tick_cnt;
        logic [2:0] rate_sel;
        logic [1:0] range_sel;
    } top_state_t;

endpackage : fan_pkg

// ### rtl/pwm_if.sv
// Link between the loop controller and the PWM waveform generator.
`timescale 1ns/1ps
interface pwm_if;
    logic [23:0] slot_cycles;
    logic [7:0] duty;
    logic period_end;
    logic pwm;
    modport ctrl (output slot_cycles, output duty, input period_end,
        input pwm);
    modport gen (input slot_cycles, input duty, output period_end,
        output pwm);
endinterface : pwm_if

// ### rtl/pwm_wave.sv
// PWM waveform generator: 240 slots per period, duty taken per period.
`timescale 1ns/1ps
`include "fan_cfg.svh"
module pwm_wave (
    input wire logic sys_clk,
    input wire logic reset_n,
    pwm_if.gen link
);
    fan_pkg::wave_state_t s;
    fan_pkg::wave_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.period_end = 1'b0;
        if ({1'b0, s.cyc_cnt} + 25'h0000001 >= {1'b0, link.slot_cycles}) begin
            next_s.cyc_cnt = 24'h000000;
            if (s.slot == `SLOT_LAST) begin // RULE11
                next_s.slot = 8'h00;
                // Duty changes only here, so no period is cut short.
                next_s.duty = link.duty; // RULE19
                next_s.period_end = 1'b1;
            end else begin
                next_s.slot = s.slot + 8'h01;
            end
        end else begin
            next_s.cyc_cnt = s.cyc_cnt + 24'h000001;
        end
        next_s.pwm = next_s.slot < next_s.duty; // RULE11
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.period_end = s.period_end;
    assign link.pwm = s.pwm;

    property p_high_slots;
        @(posedge sys_clk) disable iff (!reset_n)
        s.pwm == (s.slot < s.duty);
    endproperty
    a_high_slots: assert property (p_high_slots) // RULE11
        else $error("pwm high time does not match duty slots");

    property p_period;
        @(posedge sys_clk) disable iff (!reset_n)
        s.period_end |-> s.slot == 8'h00 && $past(s.slot) == `SLOT_LAST;
    endproperty
    a_period: assert property (p_period) // RULE11
        else $error("period did not end after slot 239");
endmodule : pwm_wave
